// *** hw/sas_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - one selected input of nine is converted into a 10-bit value.
// - control bits 7..4 pick the analog input routed to the converter.
// - only one input connects at a time; channel may change between conversions.
// - writing one to control bit 0 launches a conversion.
// - successive-approximation register starts each conversion at 200H.
// - one result bit is resolved per four steps until all ten are decided.
// - each bit takes 4 conversion clocks after a 10-clock set-up.
// - control bits 2..1 select the conversion clock rate.
// - speed code 10 gives one conversion clock per four oscillator clocks.
// - completion sets control bit 3, end of conversion, by hardware.
// - upper eight result bits go high, lower two go low.
// - after storing, the converter idles until started again.
// - a new conversion overwrites results, unread or not.
module sas_sequencer (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write address and data
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [sas_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    // axi4-lite write response
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    output logic [1:0]                     s_axi_bresp,
    // axi4-lite read
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    input  wire logic [sas_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    // analog front end
    input  wire logic                      comp_ge,
    output logic [9:0]                     dac_code,
    output logic [3:0]                     chan_sel,
    output logic                           chan_connect,
    output logic                           conv_busy,
    // interrupt
    output logic                           irq
);

    // ------------------------------------------------------------
    // operation overview
    // ------------------------------------------------------------
    // the block sits between the register bus and an analog front end
    // made of a switch matrix, a trial-code converter and a comparator.
    // only the digital sequencing lives here; the comparator answer
    // arrives on comp_ge and is taken as already synchronous to aclk.
    //
    // a conversion runs in three phases:
    //   idle   - divider held at zero, no input connected, eoc as left
    //   setup  - ten conversion-clock ticks with the mid-scale code out
    //   decide - four ticks per bit, msb first, comparator taken on the
    //            fourth tick, next lower bit then set as the trial bit
    // after the last bit the result is copied into the two result
    // registers, eoc and the interrupt status are set in the same cycle
    // and the sequencer drops back to idle on its own.
    //
    // the conversion clock is a one-cycle tick from a divider on aclk;
    // no second clock exists, so the speed field only changes how often
    // the tick fires. changing the speed field in mid-run is legal but
    // stretches or shortens the remaining steps; software is expected
    // to leave it alone until eoc is seen.
    //
    // the channel is latched at launch into conv_chan and drives the
    // switch matrix from there, so a control write during a run may
    // update the stored fields without moving the connected input.
    // codes nine and above run a full conversion with nothing
    // connected; the result is then meaningless but timing is kept.
    //
    // there is no sample-and-hold: the input must stay steady for the
    // whole run, which is a board-level matter outside this block.

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        sas_pkg::sas_state_t state;
        logic [3:0]          ctrl_chan;
        logic [1:0]          ctrl_speed;
        logic                eoc;
        logic                busy;
        logic [3:0]          div_cnt;
        logic [3:0]          step_cnt;
        logic [3:0]          bit_idx;
        logic [9:0]          sar;
        logic [3:0]          conv_chan;
        logic                connect;
        logic [7:0]          res_high;
        logic [1:0]          res_low;
        logic                irq_stat;
        logic                irq_mask;
        logic                irq;
        logic                aw_have;
        logic [9:0]          aw_idx;
        logic                w_have;
        logic [7:0]          w_data;
        logic                w_lane0;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [7:0]          rdata;
        logic [1:0]          rresp;
    } sas_regs_t;

    sas_regs_t r_reg;
    sas_regs_t r_next;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // divider last count per speed code; code 11 is the fastest
    function automatic logic [3:0] div_last(input logic [1:0] speed);
        case (speed)
            2'b00:   div_last = sas_pkg::DIV_LAST_16;
            2'b01:   div_last = sas_pkg::DIV_LAST_8;
            2'b10:   div_last = sas_pkg::DIV_LAST_4;
            default: div_last = sas_pkg::DIV_LAST_2;
        endcase
    endfunction

    // address decode shared by the write and read paths
    function automatic logic idx_mapped(input logic [9:0] idx);
        idx_mapped = (idx == sas_pkg::IDX_CONTROL)  || (idx == sas_pkg::IDX_RES_HIGH) ||
                     (idx == sas_pkg::IDX_RES_LOW)  || (idx == sas_pkg::IDX_IRQ_STAT) ||
                     (idx == sas_pkg::IDX_IRQ_MASK);
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic       tick;
        logic       done_evt;
        logic [9:0] ar_idx;
        tick     = 1'b0;
        done_evt = 1'b0;
        ar_idx   = s_axi_araddr[11:2];
        r_next   = r_reg;

        // conversion clock divider, held at zero while idle
        if (r_reg.state != sas_pkg::SAS_IDLE) begin
            if (r_reg.div_cnt == div_last(r_reg.ctrl_speed)) begin
                r_next.div_cnt = 4'h0;
                tick           = 1'b1;
            end else begin
                r_next.div_cnt = r_reg.div_cnt + 4'h1;
            end
        end

        // sequencer: set-up interval, then four steps per bit
        case (r_reg.state)
            sas_pkg::SAS_IDLE: begin
                r_next.state = sas_pkg::SAS_IDLE;
            end
            sas_pkg::SAS_SETUP: begin
                if (tick) begin
                    if (r_reg.step_cnt == sas_pkg::SETUP_LAST) begin
                        r_next.state    = sas_pkg::SAS_DECIDE;
                        r_next.step_cnt = 4'h0;
                    end else begin
                        r_next.step_cnt = r_reg.step_cnt + 4'h1;
                    end
                end
            end
            sas_pkg::SAS_DECIDE: begin
                if (tick) begin
                    if (r_reg.step_cnt == sas_pkg::BIT_LAST) begin
                        // comparator keeps or drops the trial bit
                        r_next.sar[r_reg.bit_idx] = comp_ge;
                        r_next.step_cnt           = 4'h0;
                        if (r_reg.bit_idx == 4'h0) begin
                            r_next.res_high = r_next.sar[9:2];
                            r_next.res_low  = r_next.sar[1:0];
                            r_next.eoc      = 1'b1;
                            r_next.state    = sas_pkg::SAS_IDLE;
                            done_evt        = 1'b1;
                        end else begin
                            r_next.bit_idx                     = r_reg.bit_idx - 4'h1;
                            r_next.sar[r_reg.bit_idx - 4'h1] = 1'b1;
                        end
                    end else begin
                        r_next.step_cnt = r_reg.step_cnt + 4'h1;
                    end
                end
            end
            default: begin
                r_next.state = sas_pkg::SAS_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // register bus timing
        // ------------------------------------------------------------
        // write: address and data are each taken when offered, in any
        // order, and parked until both are held. the register update
        // happens on the edge after the later of the two, together with
        // bvalid rising. both readys stay low from their take until the
        // response has been accepted, so only one write is ever open.
        //
        // read: the address is decoded straight from the bus and the
        // answer is registered on the take edge, so rvalid always comes
        // exactly one edge later. arready stays low while rvalid stands,
        // which keeps the answer stable however long rready is held off.
        //
        // only byte lane zero carries data; the other lanes are ignored
        // and a write with lane zero off is answered okay without effect.
        // unmapped indices answer slverr and change nothing.
        //
        // the start bit reads back as busy rather than as written, so a
        // poll of the control register shows a run in progress directly.

        // write channels are taken independently, in either order
        if (s_axi_awvalid && r_reg.awready) begin
            r_next.aw_have = 1'b1;
            r_next.aw_idx  = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && r_reg.wready) begin
            r_next.w_have  = 1'b1;
            r_next.w_data  = s_axi_wdata[7:0];
            r_next.w_lane0 = s_axi_wstrb[0];
        end

        // perform the write once both halves are held
        if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
            r_next.aw_have = 1'b0;
            r_next.w_have  = 1'b0;
            r_next.bvalid  = 1'b1;
            r_next.bresp   = idx_mapped(r_reg.aw_idx) ? sas_pkg::RESP_OKAY
                                                       : sas_pkg::RESP_SLVERR;
            if (r_reg.w_lane0 && r_reg.aw_idx == sas_pkg::IDX_CONTROL) begin
                r_next.ctrl_chan  = r_reg.w_data[sas_pkg::CTL_CHAN +: 4];
                r_next.ctrl_speed = r_reg.w_data[sas_pkg::CTL_SPEED +: 2];
                // a start while converting is ignored so one input stays connected
                if (r_reg.w_data[sas_pkg::CTL_START] &&
                    r_reg.state == sas_pkg::SAS_IDLE) begin
                    r_next.state     = sas_pkg::SAS_SETUP;
                    r_next.sar       = sas_pkg::SAR_MID;
                    r_next.step_cnt  = 4'h0;
                    r_next.div_cnt   = 4'h0;
                    r_next.bit_idx   = sas_pkg::MSB_IDX;
                    r_next.conv_chan = r_reg.w_data[sas_pkg::CTL_CHAN +: 4];
                    r_next.eoc       = 1'b0;
                end
            end
            if (r_reg.w_lane0 && r_reg.aw_idx == sas_pkg::IDX_IRQ_MASK) begin
                r_next.irq_mask = r_reg.w_data[0];
            end
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        r_next.awready = !r_next.aw_have && !r_next.bvalid;
        r_next.wready  = !r_next.w_have && !r_next.bvalid;

        // read: address taken, data answered on the next edge
        if (s_axi_arvalid && r_reg.arready) begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = idx_mapped(ar_idx) ? sas_pkg::RESP_OKAY
                                               : sas_pkg::RESP_SLVERR;
            case (ar_idx)
                sas_pkg::IDX_CONTROL:  r_next.rdata = {r_reg.ctrl_chan, r_reg.eoc,
                                                       r_reg.ctrl_speed, r_reg.busy};
                sas_pkg::IDX_RES_HIGH: r_next.rdata = r_reg.res_high;
                sas_pkg::IDX_RES_LOW:  r_next.rdata = {6'h00, r_reg.res_low};
                sas_pkg::IDX_IRQ_STAT: r_next.rdata = {7'h00, r_reg.irq_stat};
                sas_pkg::IDX_IRQ_MASK: r_next.rdata = {7'h00, r_reg.irq_mask};
                default:               r_next.rdata = 8'h00;
            endcase
            // reading the status clears it
            if (ar_idx == sas_pkg::IDX_IRQ_STAT) begin
                r_next.irq_stat = 1'b0;
            end
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
        r_next.arready = !r_next.rvalid;

        // a completion in the clearing cycle wins over the clear
        if (done_evt) begin
            r_next.irq_stat = 1'b1;
        end
        r_next.irq = r_next.irq_stat && r_next.irq_mask;

        // output flops: nine valid channels, codes above eight connect nothing
        r_next.busy    = (r_next.state != sas_pkg::SAS_IDLE);
        r_next.connect = r_next.busy && (r_next.conv_chan < sas_pkg::NUM_CHAN);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg            <= '0;
            r_reg.state      <= sas_pkg::SAS_IDLE;
            r_reg.ctrl_chan  <= sas_pkg::CHAN_RESET;
            r_reg.ctrl_speed <= sas_pkg::SPEED_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready  = r_reg.wready;
    assign s_axi_bvalid  = r_reg.bvalid;
    assign s_axi_bresp   = r_reg.bresp;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rvalid  = r_reg.rvalid;
    assign s_axi_rdata   = {24'h00_0000, r_reg.rdata};
    assign s_axi_rresp   = r_reg.rresp;
    assign dac_code      = r_reg.sar;
    assign chan_sel      = r_reg.conv_chan;
    assign chan_connect  = r_reg.connect;
    assign conv_busy     = r_reg.busy;
    assign irq           = r_reg.irq;

endmodule
`default_nettype wire

// *** hw/sas_pkg.sv ***
`default_nettype none
package sas_pkg;
    // ------------------------------------------------------------
    // register map: printed offsets are indices, byte address = 4 x index
    // ------------------------------------------------------------
    localparam int         ADDR_W       = 12;
    localparam logic [9:0] IDX_CONTROL  = 10'h0f7;
    localparam logic [9:0] IDX_RES_HIGH = 10'h0f8;
    localparam logic [9:0] IDX_RES_LOW  = 10'h0f9;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h0fa;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0fb;

    // control register field positions
    localparam int CTL_START = 0;
    localparam int CTL_SPEED = 1;
    localparam int CTL_EOC   = 3;
    localparam int CTL_CHAN  = 4;

    // reset values
    localparam logic [3:0] CHAN_RESET  = 4'h0;
    localparam logic [1:0] SPEED_RESET = 2'h0;

    // ------------------------------------------------------------
    // conversion timing, in conversion-clock steps
    // ------------------------------------------------------------
    localparam int         SETUP_CLKS = 10;
    localparam int         BIT_STEPS  = 4;
    localparam logic [3:0] SETUP_LAST = 4'(SETUP_CLKS - 1);
    localparam logic [3:0] BIT_LAST   = 4'(BIT_STEPS - 1);
    localparam logic [3:0] MSB_IDX    = 4'h9;
    localparam logic [9:0] SAR_MID    = 10'h200;
    localparam logic [3:0] NUM_CHAN   = 4'h9;

    // divider last counts: osc/16, osc/8, osc/4, osc/2
    localparam logic [3:0] DIV_LAST_16 = 4'hf;
    localparam logic [3:0] DIV_LAST_8  = 4'h7;
    localparam logic [3:0] DIV_LAST_4  = 4'h3;
    localparam logic [3:0] DIV_LAST_2  = 4'h1;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SAS_IDLE   = 3'b001,
        SAS_SETUP  = 3'b010,
        SAS_DECIDE = 3'b100
    } sas_state_t;
endpackage
`default_nettype wire

// *** tb/sas_seq_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module sas_seq_assertions (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus handshakes
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // converter side
    input wire logic [9:0]  dac_code,
    input wire logic [3:0]  chan_sel,
    input wire logic        chan_connect,
    input wire logic        conv_busy,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // busy length counter, cleared whenever the converter idles
    // ------------------------------------------------------------
    logic [9:0] busy_cnt_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || !conv_busy) busy_cnt_reg <= 10'h000;
        else busy_cnt_reg <= busy_cnt_reg + 10'h001;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_sar_preload: assert property (
        $rose(conv_busy) |-> dac_code == 10'h200) else $error("start code not mid-scale");
    a_setup_hold: assert property (
        $rose(conv_busy) |=> (dac_code == 10'h200) [*8]) else $error("code moved in set-up");
    a_conv_length: assert property (
        $fell(conv_busy) |-> busy_cnt_reg inside {10'h064, 10'h0c8, 10'h190, 10'h320})
        else $error("conversion length wrong");
    a_start_by_write: assert property (
        $rose(conv_busy) |-> $rose(s_axi_bvalid)) else $error("conversion without start write");
    a_one_input: assert property (
        chan_connect |-> conv_busy && chan_sel < 4'h9) else $error("input connected while idle");
    a_chan_steady: assert property (
        conv_busy && $past(conv_busy) |-> $stable(chan_sel)) else $error("channel moved in run");
    a_irq_cause: assert property (
        $rose(irq) |-> $fell(conv_busy) || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt without completion");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    a_rdata_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
    c_done: cover property ($fell(conv_busy));
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind sas_sequencer sas_seq_assertions i_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .dac_code,
    .chan_sel, .chan_connect, .conv_busy, .irq);
`default_nettype wire

// *** tb/sas_comp_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sas_comp_model (
    // converter side
    input  wire logic [9:0] dac_code,
    input  wire logic [3:0] chan_sel,
    input  wire logic       chan_connect,
    // comparator decision
    output logic            comp_ge
);
    logic [9:0] vin [0:15];
    initial for (int i = 0; i < 16; i++) vin[i] = 10'h000;
    // ideal comparator; an open input gives a code-dependent pattern, never a held level
    always_comb begin
        if (chan_connect) comp_ge = (vin[chan_sel] >= dac_code);
        else comp_ge = ^dac_code;
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic        awready, wready, bvalid, arready, rvalid, comp_ge, chan_connect, conv_busy, irq;
    logic [1:0]  bresp, rresp;
    logic [9:0]  dac_code;
    logic [3:0]  chan_sel;
    int          err_count = 0, n_compared = 0, busy_n = 0;
    localparam logic [11:0] A_CTL = {sas_pkg::IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_HI = {sas_pkg::IDX_RES_HIGH, 2'b00};
    localparam logic [11:0] A_LO = {sas_pkg::IDX_RES_LOW, 2'b00};
    localparam logic [11:0] A_ST = {sas_pkg::IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_MK = {sas_pkg::IDX_IRQ_MASK, 2'b00};
    always #20 aclk = ~aclk;
    // busy cycles are counted here so the bench never trusts the design's own timer
    always @(posedge aclk) if (conv_busy === 1'b1) busy_n <= busy_n + 1;
    sas_sequencer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .comp_ge(comp_ge),
        .dac_code(dac_code), .chan_sel(chan_sel), .chan_connect(chan_connect),
        .conv_busy(conv_busy), .irq(irq));
    sas_comp_model i_comp (.dac_code(dac_code), .chan_sel(chan_sel),
        .chan_connect(chan_connect), .comp_ge(comp_ge));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // address and data are offered together and each released when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        chk(bresp, er);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_conv(input logic [3:0] ch, input logic [1:0] sp, input logic [9:0] v);
        int b0;
        int n;
        logic [7:0] d;
        logic [1:0] r;
        i_comp.vin[ch] = v;
        b0 = busy_n;
        wr(A_CTL, {ch, 1'b0, sp, 1'b1}, 2'h0);
        rd(A_CTL, d, r);
        chk(d[3:0], {1'b0, sp, 1'b1});
        n = 0;
        while (d[3] !== 1'b1 && n < 3000) begin
            rd(A_CTL, d, r);
            n++;
        end
        chk(d, {ch, 1'b1, sp, 1'b0});
        chk(busy_n - b0, 50 * (16 >> sp));
        rd(A_HI, d, r);
        chk(d, v[9:2]);
        rd(A_LO, d, r);
        chk(d[1:0], v[1:0]);
    endtask
    // a start during a run keeps the latched input; code nine connects nothing
    task automatic t_restart;
        logic [7:0] d;
        logic [1:0] r;
        int b0;
        i_comp.vin[2] = 10'h2a5;
        b0 = busy_n;
        wr(A_CTL, {4'h2, 1'b0, 2'b11, 1'b1}, 2'h0);
        wr(A_CTL, {4'h3, 1'b0, 2'b11, 1'b1}, 2'h0);
        chk(chan_sel, 4'h2);
        chk(chan_connect, 1'b1);
        d = 8'h00;
        for (int k = 0; k < 300 && d[3] !== 1'b1; k++) rd(A_CTL, d, r);
        chk(d, {4'h3, 1'b1, 2'b11, 1'b0});
        chk(busy_n - b0, 100);
        rd(A_HI, d, r);
        chk(d, 8'ha9);
        wr(A_CTL, {4'h9, 1'b0, 2'b11, 1'b1}, 2'h0);
        chk(conv_busy, 1'b1);
        chk(chan_connect, 1'b0);
        d = 8'h00;
        for (int k = 0; k < 300 && d[3] !== 1'b1; k++) rd(A_CTL, d, r);
        chk(chan_connect, 1'b0);
    endtask
    task automatic t_irq;
        logic [7:0] d;
        logic [1:0] r;
        wr(A_MK, 8'h01, 2'h0);
        t_conv(4'h4, 2'b11, 10'h3ff);
        chk(irq, 1'b1);
        rd(A_ST, d, r);
        chk(d[0], 1'b1);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        wr(A_MK, 8'h00, 2'h0);
        t_conv(4'h5, 2'b11, 10'h000);
        chk(irq, 1'b0);
        rd(A_ST, d, r);
        rd(A_ST, d, r);
        chk(d[0], 1'b0);
    endtask
    task automatic t_bus;
        logic [7:0] d;
        logic [1:0] r;
        wr(12'h000, 8'hff, 2'h2);
        rd(12'h000, d, r);
        chk({r, d}, {2'h2, 8'h00});
        wr(A_HI, 8'h55, 2'h0);
        rd(A_HI, d, r);
        chk(d, 8'h00);
    endtask
    task automatic t_reset_mid;
        logic [7:0] d;
        logic [1:0] r;
        wr(A_CTL, {4'h2, 1'b0, 2'b00, 1'b1}, 2'h0);
        repeat (30) @(posedge aclk);
        do_reset;
        chk(conv_busy, 1'b0);
        rd(A_CTL, d, r);
        chk(d, 8'h00);
        repeat (900) @(posedge aclk);
        rd(A_CTL, d, r);
        chk(d, 8'h00);
    endtask
    initial begin
        logic [7:0] d;
        logic [1:0] r;
        do_reset;
        rd(A_CTL, d, r);
        chk(d, 8'h00);
        t_conv(4'h8, 2'b00, 10'h3ff);
        t_conv(4'h0, 2'b01, 10'h000);
        t_conv(4'h7, 2'b10, 10'h200);
        t_conv(4'h1, 2'b11, 10'h1ff);
        for (int ch = 0; ch < 9; ch++) t_conv(4'(ch), 2'b11, 10'(ch * 113 + 5));
        t_restart;
        t_irq;
        t_bus;
        t_reset_mid;
        end_sim;
    end
    initial begin
        repeat (40000) @(posedge aclk);
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim;
    end
endmodule
`default_nettype wire
